// file: verilog/iocip_defs.vh
/*
 Constants for the isolated I/O change-interrupt port.
 Assumes inclusion by bare name from the design files.
*/
`ifndef IOCIP_DEFS_VH
`define IOCIP_DEFS_VH
`define IOCIP_CH_W 8
`define IOCIP_SEL_W 3
`define IOCIP_FLAG_W 4
`define IOCIP_FLAG_SEL_W 2
`define IOCIP_SEL_NONE 3'h0
`define IOCIP_DATA_ADDR_OFS 3'h0
`define IOCIP_MASK_ADDR_OFS 3'h1
`define IOCIP_OUT_RST 8'h00
`define IOCIP_MASK_RST 8'hFF
`define IOCIP_ST_IDLE 2'h0
`define IOCIP_ST_CYC 2'h1
`endif

// file: verilog/iocip_sync.v
/*
 Two-flop synchroniser, parameterised width.
 Assumes input is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module iocip_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire resetn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// file: verilog/iocip_port.v
/*
 Eight-channel isolated I/O port with change-of-state interrupt.
 Assumes bus pins arrive asynchronously to clk at 20 MHz, much faster
 than bus timing pulses; open-drain lines are resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iocip_defs.vh"
module iocip_port (
	input wire clk,
	input wire resetn,
	input wire clear_n,
	input wire cycle_start_pulse,
	input wire cycle_end_pulse,
	input wire memory_read_strobe_n,
	input wire [2:0] io_select_lines,
	input wire [7:0] data_bus_bits_in,
	output reg [7:0] data_bus_bits_out,
	output reg data_bus_bits_oe,
	input wire [2:0] jumper_io_addr,
	input wire [1:0] jumper_flag_sel,
	input wire [7:0] channel_in,
	output reg [7:0] channel_out,
	output reg int_req_n_oe,
	output reg [3:0] external_flag_lines_n_oe
);
	localparam [1:0] ST_IDLE = `IOCIP_ST_IDLE;
	localparam [1:0] ST_CYC = `IOCIP_ST_CYC;

	// Every pin group, jumpers too, passes its own two-flop synchroniser
	wire start_s;
	wire end_s;
	wire rd_n_s;
	wire [`IOCIP_SEL_W-1:0] sel_s;
	wire [`IOCIP_CH_W-1:0] db_s;
	wire [`IOCIP_SEL_W-1:0] jio_s;
	wire [`IOCIP_FLAG_SEL_W-1:0] jfs_s;
	wire [`IOCIP_CH_W-1:0] ch_s;
	wire clr_ok;

	iocip_sync #(.W(1)) u_start_sync (
		.clk(clk),
		.resetn(resetn),
		.d(cycle_start_pulse),
		.q(start_s)
	);

	iocip_sync #(.W(1)) u_end_sync (
		.clk(clk),
		.resetn(resetn),
		.d(cycle_end_pulse),
		.q(end_s)
	);

	iocip_sync #(.W(1)) u_rd_sync (
		.clk(clk),
		.resetn(resetn),
		.d(memory_read_strobe_n),
		.q(rd_n_s)
	);

	iocip_sync #(.W(`IOCIP_SEL_W)) u_sel_sync (
		.clk(clk),
		.resetn(resetn),
		.d(io_select_lines),
		.q(sel_s)
	);

	iocip_sync #(.W(`IOCIP_CH_W)) u_db_sync (
		.clk(clk),
		.resetn(resetn),
		.d(data_bus_bits_in),
		.q(db_s)
	);

	iocip_sync #(.W(`IOCIP_SEL_W)) u_jio_sync (
		.clk(clk),
		.resetn(resetn),
		.d(jumper_io_addr),
		.q(jio_s)
	);

	iocip_sync #(.W(`IOCIP_FLAG_SEL_W)) u_jfs_sync (
		.clk(clk),
		.resetn(resetn),
		.d(jumper_flag_sel),
		.q(jfs_s)
	);

	iocip_sync #(.W(`IOCIP_CH_W)) u_ch_sync (
		.clk(clk),
		.resetn(resetn),
		.d(channel_in),
		.q(ch_s)
	);

	// Starts low after reset, so the port stays cleared two more edges
	iocip_sync #(.W(1)) u_clr_sync (
		.clk(clk),
		.resetn(resetn),
		.d(clear_n),
		.q(clr_ok)
	);

	reg start_d;
	reg end_d;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [`IOCIP_CH_W-1:0] ch_prev;
	reg [`IOCIP_CH_W-1:0] mask;
	reg [`IOCIP_CH_W-1:0] pending;
	reg [`IOCIP_CH_W-1:0] next_pending;
	reg is_read;
	reg is_data;
	reg hit;
	reg any_next;
	wire [`IOCIP_SEL_W-1:0] data_addr;
	wire [`IOCIP_SEL_W-1:0] mask_addr;
	wire port_on;
	wire start_fall;
	wire end_fall;
	wire in_cyc;
	wire data_hit;
	wire mask_hit;
	wire [`IOCIP_CH_W-1:0] change;
	wire write_done;
	wire read_done;
	wire [`IOCIP_FLAG_W-1:0] flag_one;

	assign start_fall = start_d & ~start_s;
	assign end_fall = end_d & ~end_s;
	assign in_cyc = (state == ST_CYC);
	// Port owns two consecutive jumper addresses, data then mask; select zero is no I/O
	assign data_addr = jio_s + `IOCIP_DATA_ADDR_OFS;
	assign mask_addr = jio_s + `IOCIP_MASK_ADDR_OFS;
	assign port_on = (jio_s != `IOCIP_SEL_NONE) && (sel_s != `IOCIP_SEL_NONE);
	assign data_hit = port_on && (sel_s == data_addr);
	assign mask_hit = port_on && (sel_s == mask_addr);
	assign change = (ch_s ^ ch_prev) & ~mask;
	assign write_done = in_cyc && end_fall && hit && !is_read;
	assign read_done = in_cyc && end_fall && hit && is_read && is_data;
	assign flag_one = {{(`IOCIP_FLAG_W-1){1'h0}}, 1'h1};

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_fall) begin
					next_state = ST_CYC;
				end
			end
			ST_CYC: begin
				if (end_fall) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// New change wins over clear from a read in the same cycle
	always @* begin
		next_pending = pending;
		if (read_done) begin
			next_pending = {`IOCIP_CH_W{1'h0}};
		end
		next_pending = next_pending | change;
		any_next = |next_pending;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			start_d <= 1'h0;
			end_d <= 1'h0;
		end else if (!clr_ok) begin
			state <= ST_IDLE;
			start_d <= 1'h0;
			end_d <= 1'h0;
		end else begin
			state <= next_state;
			start_d <= start_s;
			end_d <= end_s;
		end
	end

	// Latch decode while lines are stable inside the window
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hit <= 1'h0;
			is_data <= 1'h0;
			is_read <= 1'h0;
		end else if (!clr_ok || !in_cyc) begin
			hit <= 1'h0;
			is_data <= 1'h0;
			is_read <= 1'h0;
		end else begin
			hit <= data_hit | mask_hit;
			is_data <= data_hit;
			is_read <= rd_n_s;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ch_prev <= {`IOCIP_CH_W{1'h0}};
			pending <= {`IOCIP_CH_W{1'h0}};
		end else if (!clr_ok) begin
			// Track levels during clear so its release raises no false change
			ch_prev <= ch_s;
			pending <= {`IOCIP_CH_W{1'h0}};
		end else begin
			ch_prev <= ch_s;
			pending <= next_pending;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask <= `IOCIP_MASK_RST;
		end else if (!clr_ok) begin
			mask <= `IOCIP_MASK_RST;
		end else if (write_done && !is_data) begin
			mask <= db_s;
		end
	end

	// Written data taken at end pulse fall, bit n to channel n
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_out <= `IOCIP_OUT_RST;
		end else if (!clr_ok) begin
			channel_out <= `IOCIP_OUT_RST;
		end else if (write_done && is_data) begin
			channel_out <= db_s;
		end
	end

	// Drive bus only for an input cycle to our address
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_bus_bits_out <= {`IOCIP_CH_W{1'h0}};
			data_bus_bits_oe <= 1'h0;
		end else if (!clr_ok) begin
			data_bus_bits_out <= {`IOCIP_CH_W{1'h0}};
			data_bus_bits_oe <= 1'h0;
		end else begin
			data_bus_bits_out <= data_hit ? ch_s : mask;
			data_bus_bits_oe <= in_cyc && !end_fall && rd_n_s && (data_hit | mask_hit);
		end
	end

	// Flag and interrupt share one next value, so they never disagree
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_req_n_oe <= 1'h0;
			external_flag_lines_n_oe <= {`IOCIP_FLAG_W{1'h0}};
		end else if (!clr_ok) begin
			int_req_n_oe <= 1'h0;
			external_flag_lines_n_oe <= {`IOCIP_FLAG_W{1'h0}};
		end else begin
			int_req_n_oe <= any_next;
			if (any_next) begin
				external_flag_lines_n_oe <= flag_one << jfs_s;
			end else begin
				external_flag_lines_n_oe <= {`IOCIP_FLAG_W{1'h0}};
			end
		end
	end
endmodule
`default_nettype wire

// file: bench/iocip_props.sv
/* Checker for iocip_port ports. Assumes bind below. */
`timescale 1ns/1ps
`default_nettype none
module iocip_props(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clear_n,
	input wire logic memory_read_strobe_n,
	input wire logic [2:0] io_select_lines,
	input wire logic [1:0] jumper_flag_sel,
	input wire logic [7:0] channel_out,
	input wire logic data_bus_bits_oe,
	input wire logic int_req_n_oe,
	input wire logic [3:0] external_flag_lines_n_oe);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	flag_one_a: assert property ($onehot0(external_flag_lines_n_oe)) else $error("flag");
	flag_sel_a: assert property (external_flag_lines_n_oe[jumper_flag_sel]==int_req_n_oe) else $error("flag");
	clr_rst_a: assert property (!clear_n[*4] |-> !int_req_n_oe&&channel_out==8'h00) else $error("clr");
	rd_dir_a: assert property ($rose(data_bus_bits_oe) |-> $past(memory_read_strobe_n,3)) else $error("dir");
	rd_sel_a: assert property (data_bus_bits_oe |-> io_select_lines!=3'h0) else $error("sel");
	wr_only_a: assert property ($changed(channel_out) |-> !$past(memory_read_strobe_n,3)||!clear_n) else $error("wr");
	rd_clr_a: assert property ($fell(data_bus_bits_oe) |-> ##[0:4] !int_req_n_oe) else $error("int");
	rst_val_a: assert property ($rose(resetn) |-> !data_bus_bits_oe&&!int_req_n_oe) else $error("rst");
endmodule
bind iocip_port iocip_props iocip_props_i(.clk,.resetn,.clear_n,.memory_read_strobe_n,.io_select_lines,
	.jumper_flag_sel,.channel_out,.data_bus_bits_oe,.int_req_n_oe,.external_flag_lines_n_oe);
`default_nettype wire

// file: bench/iocip_bus.sv
/* Backplane bus model. Assumes one driver at a time. */
`timescale 1ns/1ps
`default_nettype none
module iocip_bus(
	input wire logic clk,
	input wire logic [7:0] drv,
	input wire logic drv_oe,
	input wire logic [7:0] wd,
	input wire logic wen,
	input wire logic irq_oe,
	input wire logic [3:0] flag_oe,
	output logic [7:0] bus,
	output wire logic irq_n,
	output wire logic [3:0] flag_n);
	logic [7:0] pat = 8'h55;
	// Released bus toggles so no stale value passes
	always @(posedge clk) pat <= ~pat;
	assign bus = drv_oe ? drv : wen ? wd : pat;
	// Open-drain lines with pull-ups
	assign irq_n = !irq_oe;
	assign flag_n = ~flag_oe;
endmodule
`default_nettype wire

// file: bench/tb_iocip_port.sv
/* Bench for iocip_port. Assumes port at 2, mask at 3. */
`timescale 1ns/1ps
`default_nettype none
module tb_iocip_port;
	logic clk=0,resetn=0,clear_n=1,st=0,en=0,rs=1,wen=0,doe,ioe,irq_n,seen=0;
	logic [1:0] jfs=0;
	logic [2:0] sel=0;
	logic [3:0] foe,flag_n;
	logic [7:0] wd=0,ch=0,r,dout,dbus,chout,q[$];
	int err_total=0,n_tests=0;
	always #25 clk=~clk;
	iocip_port iocip_port_i(.clk,.resetn,.clear_n,.cycle_start_pulse(st),.cycle_end_pulse(en),
		.memory_read_strobe_n(rs),.io_select_lines(sel),.data_bus_bits_in(dbus),.data_bus_bits_out(dout),
		.data_bus_bits_oe(doe),.jumper_io_addr(3'h2),.jumper_flag_sel(jfs),.channel_in(ch),
		.channel_out(chout),.int_req_n_oe(ioe),.external_flag_lines_n_oe(foe));
	iocip_bus iocip_bus_i(.clk,.drv(dout),.drv_oe(doe),.wd,.wen,.irq_oe(ioe),.flag_oe(foe),.bus(dbus),.irq_n,
		.flag_n);
	task chk_rd(logic [7:0] e,logic [7:0] s);
		n_tests++;
		if (e!==s) begin
			err_total++;
			$display("wrong value read exp %h got %h",e,s);
		end
	endtask
	task chk_irq(logic e,logic s);
		n_tests++;
		if (e!==s) begin
			err_total++;
			$display("wrong value irq exp %h got %h",e,s);
		end
	endtask
	task chk_flag(logic [3:0] e,logic [3:0] s);
		n_tests++;
		if (e!==s) begin
			err_total++;
			$display("wrong value flag exp %h got %h",e,s);
		end
	endtask
	task chk_out(logic [7:0] e,logic [7:0] s);
		n_tests++;
		if (e!==s) begin
			err_total++;
			$display("wrong value out exp %h got %h",e,s);
		end
	endtask
	task print_verdict;
		$display("errors %0d checks %0d",err_total,n_tests);
		if (err_total==0&&n_tests>0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cyc(logic [2:0] a,logic rd,logic [7:0] d);
		sel=a;
		rs=rd;
		wd=d;
		wen=!rd;
		st=1;
		repeat(5) @(negedge clk);
		st=0;
		repeat(6) @(negedge clk);
		en=1;
		repeat(5) @(negedge clk);
		en=0;
		// Hold past the synchronised end
		repeat(8) @(negedge clk);
		sel=0;
		rs=1;
		wen=0;
		// Idle gap so two cycles never touch in one step
		@(negedge clk);
	endtask
	always @(negedge clk) begin
		if (doe===1'h1&&!seen) begin
			if (q.size()==0) begin
				err_total++;
				$display("wrong value read exp none got %h",dout);
			end else begin
				chk_rd(q.pop_front(),dout);
			end
		end
		seen=doe;
	end
	// Tests take about 550 cycles; 6000 leaves ample margin
	initial begin
		#300us;
		err_total++;
		print_verdict;
	end
	initial begin
		void'($urandom(68));
		jfs=2'($urandom);
		repeat(12) @(negedge clk);
		resetn=1;
		repeat(3) @(negedge clk);
		cyc(3'h3,0,8'h00);
		for (int i=0;i<8;i++) begin
			ch=ch^(8'h01<<i);
			repeat(6) @(negedge clk);
			chk_irq(1'h1,!irq_n);
			chk_flag(~(4'h1<<jfs),flag_n);
			q.push_back(ch);
			cyc(3'h2,1,8'h00);
			chk_irq(1'h0,!irq_n);
			chk_flag(4'hF,flag_n);
		end
		ch=~ch;
		repeat(6) @(negedge clk);
		chk_irq(1'h1,!irq_n);
		q.push_back(ch);
		cyc(3'h2,1,8'h00);
		chk_irq(1'h0,!irq_n);
		repeat(3) begin
			r=8'($urandom);
			cyc(3'h2,0,r);
			chk_out(r,chout);
		end
		cyc(3'h5,0,~r);
		chk_out(r,chout);
		cyc(3'h3,0,8'hFF);
		ch=~ch;
		repeat(6) @(negedge clk);
		chk_irq(1'h0,!irq_n);
		q.push_back(8'hFF);
		cyc(3'h3,1,8'h00);
		cyc(3'h3,0,8'h5A);
		cyc(3'h2,0,8'hA5);
		chk_out(8'hA5,chout);
		clear_n=0;
		repeat(5) @(negedge clk);
		clear_n=1;
		chk_out(8'h00,chout);
		q.push_back(8'hFF);
		cyc(3'h3,1,8'h00);
		chk_rd(8'h00,8'(q.size()));
		print_verdict;
	end
endmodule
`default_nettype wire
